// *** ets_top.sv ***
// Self-test burst generator, frame counters and APB register file.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - Frames of a burst go out back to back with minimum gap, random idle between bursts.
// - Frames per burst are random, limited by the frame count mask.
// - Fill selector forces addresses, type/length and payload to ones or zeros.
// - Unforced addresses are random, or a random stored pair per burst.
// - Unforced type/length holds frame length minus the 18 overhead bytes.
// - Unforced payload is random data.
// - After a burst: random idle, random sleep, random wake-up, then next burst.
// - Sleep length comes from the sleep mask and never drops below the minimum.
// - A control bit decides whether low-power idle is signalled during sleep.
// - Carrier timer select makes wake-up wait on the carrier low-power timer.
// - Burst mode runs until software clears the run enable bit.
// - With timed run set, burst mode stops itself after about one second.
// - Per-pair sent counters; set then clear of the clear bit zeroes them.
// - Three checksum checkers: one on MAC transmit data, two on line receive.
// - Transmit checker counts only when enabled; disabling zeroes its counters.
// - Receive sets count all frames, or only those matching the pair source.
// - Receive counters count only when enabled; disabling zeroes them.
// - With link-down clear set, a link drop zeroes all self-test counters.
// - Bursts wait for link up unless the force bit bypasses it.
// - Frames carry preamble, start delimiter and a correct checksum.
module ets_top
  import ets_pkg::*;
#(
  parameter int unsigned RUN_LEN = RUN_CYCLES
) (
  input  wire logic         clk_sys_i,
  input  wire logic         rst_i,
  input  wire ets_apb_req_t apb_i,
  output logic [31:0]       prdata_o,
  output logic              pready_o,
  output logic              pslverr_o,
  input  wire ets_gmii_t    mac_tx_i,
  input  wire ets_gmii_t    line_rx_i,
  output ets_gmii_t         line_tx_o,
  output logic              line_lpi_o,
  input  wire logic         link_up_i,
  input  wire logic         crs_timer_done_i
);

  typedef struct packed {
    logic [15:0]           ctrl;
    logic [15:0]           fmask;
    logic [15:0]           smask;
    logic [15:0]           smin;
    logic [1:0][47:0]      da;
    logic [1:0][47:0]      sa;
    logic [7:0][31:0]      cnt;
    logic [31:0]           rdata;
    logic                  link;
    ets_gen_t              st;
    logic [15:0]           left;
    logic [10:0]           bidx;
    logic [10:0]           plen;
    logic                  pair;
    logic [47:0]           fda;
    logic [47:0]           fsa;
    logic [31:0]           crc;
    logic [31:0]           lfsr;
    logic [15:0]           tmr;
    logic [31:0]           runc;
    ets_gmii_t             tx;
    logic                  lpi;
  } ets_top_t;

  ets_top_t s_q, s_d;

  logic        tx_good, tx_bad;
  logic [1:0]  rx_good, rx_bad;
  logic [1:0][47:0] rx_da;
  logic        acc_wr, setup;
  logic        wake_done;
  logic [10:0] fb, k;
  logic [7:0]  gb;
  logic [15:0] slp;

  // Observation only of the MAC stream.
  ets_crc_chk u_tx_chk (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .data_i    (mac_tx_i),
    .good_o    (tx_good),
    .bad_o     (tx_bad),
    .dest_o    ()
  );

  for (genvar g = 0; g < 2; g++) begin : g_rx
    ets_crc_chk u_rx_chk (
      .clk_sys_i (clk_sys_i),
      .rst_i     (rst_i),
      .data_i    (line_rx_i),
      .good_o    (rx_good[g]),
      .bad_o     (rx_bad[g]),
      .dest_o    (rx_da[g])
    );
  end

  function automatic logic [5:0] reg_idx(input logic [11:0] a);
    reg_idx = {1'b0, a[6:2]};
    if (a[11:7] != 5'h00 || a[1:0] != 2'h0 || (a[6:2] > 5'h04 && a[6:2] < 5'h08)) begin
      reg_idx = 6'h3f;
    end
  endfunction

  function automatic logic [7:0] addr_byte(input logic [47:0] v, input logic [10:0] i);
    logic [47:0] sh;
    sh = v >> (8 * (5 - int'(i)));
    return sh[7:0];
  endfunction

  assign setup     = apb_i.psel && !apb_i.penable;
  assign acc_wr    = apb_i.psel && apb_i.penable && apb_i.pwrite;
  assign pready_o  = 1'b1;
  assign pslverr_o = apb_i.psel && apb_i.penable && (reg_idx(apb_i.paddr) == 6'h3f);
  assign prdata_o  = s_q.rdata;
  assign line_tx_o = s_q.tx;
  assign line_lpi_o = s_q.lpi;
  assign fb        = s_q.bidx - PRE_LEN;
  assign k         = fb - HDR_LEN - s_q.plen;
  assign slp       = s_q.lfsr[15:0] & s_q.smask;
  assign wake_done = s_q.ctrl[B_CRS] ? crs_timer_done_i : (s_q.tmr == 16'h0000);

  always_comb begin
    logic [5:0] ri;
    logic [2:0] pi;
    ri = reg_idx(apb_i.paddr);
    pi = ri[2:0];
    gb = 8'h00;
    s_d = s_q;
    s_d.lfsr = {s_q.lfsr[0], s_q.lfsr[31:1]} ^ (s_q.lfsr[0] ? 32'h00200003 : 32'h00000000);
    s_d.link = link_up_i;
    s_d.tx.en = 1'b0;
    s_d.tx.er = 1'b0;
    s_d.tx.d  = 8'h00;
    s_d.lpi = 1'b0;

    if (setup) begin
      case (ri)
        6'h00:   s_d.rdata = {16'h0000, s_q.ctrl};
        6'h01:   s_d.rdata = {16'h0000, s_q.fmask};
        6'h02:   s_d.rdata = {16'h0000, s_q.smask};
        6'h03:   s_d.rdata = {16'h0000, s_q.smin};
        6'h04:   s_d.rdata = {25'h0000000, s_q.link, s_q.st};
        6'h08, 6'h09, 6'h0a, 6'h0b, 6'h0c, 6'h0d, 6'h0e, 6'h0f: begin
          if (pi[1]) begin
            s_d.rdata = pi[0] ? {16'h0000, s_q.sa[pi[2]][47:32]} : s_q.sa[pi[2]][31:0];
          end else begin
            s_d.rdata = pi[0] ? {16'h0000, s_q.da[pi[2]][47:32]} : s_q.da[pi[2]][31:0];
          end
        end
        6'h10, 6'h11, 6'h12, 6'h13, 6'h14, 6'h15, 6'h16, 6'h17: s_d.rdata = s_q.cnt[pi];
        default: s_d.rdata = 32'h00000000;
      endcase
    end
    if (acc_wr) begin
      case (ri)
        6'h00:   s_d.ctrl = apb_i.pwdata[15:0];
        6'h01:   s_d.fmask = apb_i.pwdata[15:0];
        6'h02:   s_d.smask = apb_i.pwdata[15:0];
        6'h03:   s_d.smin = apb_i.pwdata[15:0];
        6'h08, 6'h09, 6'h0a, 6'h0b, 6'h0c, 6'h0d, 6'h0e, 6'h0f: begin
          if (pi[1] && pi[0]) s_d.sa[pi[2]][47:32] = apb_i.pwdata[15:0];
          else if (pi[1]) s_d.sa[pi[2]][31:0] = apb_i.pwdata;
          else if (pi[0]) s_d.da[pi[2]][47:32] = apb_i.pwdata[15:0];
          else s_d.da[pi[2]][31:0] = apb_i.pwdata;
        end
        default: s_d.rdata = s_q.rdata;
      endcase
    end

    // Run until cleared; timed run ends itself.
    if (s_q.ctrl[B_RUN] && s_q.ctrl[B_TIMED]) begin
      s_d.runc = s_q.runc + 32'h1;
      if (s_q.runc >= 32'(RUN_LEN - 1)) begin
        s_d.ctrl[B_RUN] = 1'b0;
        s_d.runc = 32'h0;
      end
    end else begin
      s_d.runc = 32'h0;
    end

    if (s_q.tmr != 16'h0000) begin
      s_d.tmr = s_q.tmr - 16'h1;
    end
    case (s_q.st)
      S_IDLE: begin
        // Link or force needed to start.
        if (s_q.ctrl[B_ST_EN] && s_q.ctrl[B_MODE] && s_q.ctrl[B_RUN] &&
            (s_q.link || s_q.ctrl[B_FORCE])) begin
          s_d.left = (s_q.lfsr[15:0] & s_q.fmask) | 16'h0001;
          // Stored pair picked once per burst.
          s_d.pair = s_q.lfsr[16];
          s_d.st   = S_FRM;
          s_d.bidx = 11'h000;
        end
      end
      S_FRM: begin
        s_d.tx.en = 1'b1;
        s_d.bidx  = s_q.bidx + 11'h001;
        if (s_q.bidx == 11'h000) begin
          s_d.plen = PAY_MIN + {1'b0, s_q.lfsr[9:0]};
          s_d.crc  = CRC_INIT;
          if (s_q.ctrl[B_RNDADR]) begin
            s_d.fda = {s_q.lfsr[31:16], s_q.lfsr[31:0]} & 48'hfeffffffffff;
            s_d.fsa = {s_q.lfsr[15:0], s_q.lfsr[31:0]} & 48'hfeffffffffff;
          end else begin
            s_d.fda = s_q.da[s_q.pair];
            s_d.fsa = s_q.sa[s_q.pair];
          end
        end
        if (s_q.bidx < PRE_LEN - 11'h001) begin
          gb = PRE_BYTE;
        end else if (s_q.bidx == PRE_LEN - 11'h001) begin
          gb = SFD_BYTE;
        end else if (fb < HDR_LEN + s_q.plen) begin
          if (fb < 11'h006) gb = addr_byte(s_q.fda, fb);
          else if (fb < 11'h00c) gb = addr_byte(s_q.fsa, fb - 11'h006);
          else if (fb == 11'h00c) gb = {5'h00, s_q.plen[10:8]};
          else if (fb == 11'h00d) gb = s_q.plen[7:0];
          else gb = s_q.lfsr[7:0];
          if (s_q.ctrl[B_FILL+:2] == FILL_ZERO) gb = 8'h00;
          else if (s_q.ctrl[B_FILL+:2] == FILL_ONES) gb = 8'hff;
          s_d.crc = ets_crc_byte(s_q.crc, gb);
        end else begin
          gb = 8'(~(s_q.crc >> (8 * int'(k[1:0]))));
          if (k == FCS_LEN - 11'h001) begin
            s_d.cnt[s_q.pair] = s_q.cnt[s_q.pair] + 32'h1;
            s_d.left = s_q.left - 16'h1;
            s_d.st   = S_IFG;
            s_d.tmr  = IFG_BYTES - 16'h1;
          end
        end
        s_d.tx.d = gb;
      end
      S_IFG: begin
        if (s_q.tmr == 16'h0000) begin
          s_d.bidx = 11'h000;
          if (s_q.left != 16'h0000 && s_q.ctrl[B_RUN]) begin
            s_d.st = S_FRM;
          end else begin
            s_d.st  = S_GAP;
            s_d.tmr = s_q.lfsr[15:0] & IDLE_MASK;
          end
        end
      end
      S_GAP: begin
        if (s_q.tmr == 16'h0000) begin
          s_d.st = S_SLEEP;
          s_d.tmr = (slp < s_q.smin) ? s_q.smin : slp;
        end
      end
      S_SLEEP: begin
        s_d.lpi = s_q.ctrl[B_LPI] && (s_q.tmr != 16'h0000);
        if (s_q.tmr == 16'h0000) begin
          s_d.st  = S_WAKE;
          s_d.tmr = s_q.lfsr[15:0] & WAKE_MASK;
        end
      end
      S_WAKE: begin
        if (wake_done) begin
          s_d.st = S_IDLE;
        end
      end
      default: s_d.st = S_IDLE;
    endcase

    if (s_q.ctrl[B_TXCHK]) begin
      s_d.cnt[2] = s_q.cnt[2] + {31'h0, tx_good};
      s_d.cnt[3] = s_q.cnt[3] + {31'h0, tx_bad};
    end else begin
      s_d.cnt[2] = 32'h0;
      s_d.cnt[3] = 32'h0;
    end
    for (int r = 0; r < 2; r++) begin
      // Optional destination match; enable and clear.
      if (s_q.ctrl[B_RXCHK]) begin
        if (!s_q.ctrl[B_QUAL1 + r] || rx_da[r] == s_q.sa[r]) begin
          s_d.cnt[4 + 2*r] = s_q.cnt[4 + 2*r] + {31'h0, rx_good[r]};
          s_d.cnt[5 + 2*r] = s_q.cnt[5 + 2*r] + {31'h0, rx_bad[r]};
        end
      end else begin
        s_d.cnt[4 + 2*r] = 32'h0;
        s_d.cnt[5 + 2*r] = 32'h0;
      end
    end
    if (s_q.ctrl[B_PCLR]) begin
      s_d.cnt[0] = 32'h0;
      s_d.cnt[1] = 32'h0;
    end
    if (s_q.ctrl[B_LDCLR] && s_q.link && !link_up_i) begin
      s_d.cnt = '0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      s_q       <= '0;
      s_q.ctrl  <= CTRL_RST;
      s_q.fmask <= FMASK_RST;
      s_q.smask <= SMASK_RST;
      s_q.smin  <= SMIN_RST;
      s_q.st    <= S_IDLE;
      s_q.lfsr  <= CRC_INIT;
    end else begin
      s_q <= s_d;
    end
  end

  a_timed_run_stop: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (s_q.ctrl[B_RUN] && s_q.ctrl[B_TIMED] && s_q.runc >= 32'(RUN_LEN - 1) && !acc_wr)
      |=> !s_q.ctrl[B_RUN])
    else $error("timed run did not stop");

  a_lpi_in_sleep: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    line_lpi_o |-> ($past(s_q.st) == S_SLEEP && $past(s_q.ctrl[B_LPI])))
    else $error("low-power idle outside sleep");

  a_sleep_floor: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (s_q.st == S_SLEEP && $past(s_q.st) == S_GAP) |-> s_q.tmr >= $past(s_q.smin))
    else $error("sleep shorter than minimum");

  a_link_gate: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (s_q.st == S_FRM && $past(s_q.st) == S_IDLE) |-> $past(s_q.link || s_q.ctrl[B_FORCE]))
    else $error("burst started without link");

  a_sfd_place: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (s_q.st == S_FRM && s_q.bidx == PRE_LEN && s_q.tx.en) |-> s_q.tx.d == SFD_BYTE)
    else $error("delimiter misplaced");

  a_tx_cnt_clr: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !s_q.ctrl[B_TXCHK] && !acc_wr |=> (s_q.cnt[2] == 32'h0 && s_q.cnt[3] == 32'h0))
    else $error("transmit counters not cleared");

  a_rx_cnt_clr: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !s_q.ctrl[B_RXCHK] && !acc_wr |=> (s_q.cnt[4] == 32'h0 && s_q.cnt[7] == 32'h0))
    else $error("receive counters not cleared");

  a_fill_zero: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (s_q.st == S_FRM && s_q.tx.en && s_q.bidx > PRE_LEN && s_q.bidx <= PRE_LEN + HDR_LEN
     && s_q.ctrl[B_FILL+:2] == FILL_ZERO && $stable(s_q.ctrl)) |-> s_q.tx.d == 8'h00)
    else $error("fill not forced to zero");

endmodule // ets_top
`default_nettype wire

// *** ets_pkg.sv ***
// Shared constants, types and checksum function of the Ethernet self-test block.
package ets_pkg;

  localparam int unsigned CLK_HZ      = 50_000_000;
  localparam int unsigned RUN_TIME_MS = 1000;
  localparam int unsigned RUN_CYCLES  = (CLK_HZ / 1000) * RUN_TIME_MS;

  localparam logic [7:0]  PRE_BYTE    = 8'h55;
  localparam logic [7:0]  SFD_BYTE    = 8'hd5;
  localparam logic [10:0] PRE_LEN     = 11'h008;
  localparam logic [10:0] HDR_LEN     = 11'h00e;
  localparam logic [10:0] FCS_LEN     = 11'h004;
  localparam logic [10:0] PAY_MIN     = 11'h02e;
  localparam logic [15:0] IFG_BYTES   = 16'h000c;
  localparam logic [15:0] IDLE_MASK   = 16'h00ff;
  localparam logic [15:0] WAKE_MASK   = 16'h003f;

  localparam logic [31:0] CRC_POLY    = 32'hedb88320;
  localparam logic [31:0] CRC_INIT    = 32'hffffffff;
  localparam logic [31:0] CRC_RESIDUE = 32'hdebb20e3;

  localparam logic [11:0] OFS_CTRL    = 12'h000;
  localparam logic [11:0] OFS_FMASK   = 12'h004;
  localparam logic [11:0] OFS_SMASK   = 12'h008;
  localparam logic [11:0] OFS_SMIN    = 12'h00c;
  localparam logic [11:0] OFS_STATUS  = 12'h010;
  localparam logic [11:0] OFS_PAIR    = 12'h020;
  localparam logic [11:0] OFS_CNT     = 12'h040;

  localparam int unsigned B_ST_EN     = 0;
  localparam int unsigned B_MODE      = 1;
  localparam int unsigned B_RUN       = 2;
  localparam int unsigned B_FORCE     = 3;
  localparam int unsigned B_TIMED     = 4;
  localparam int unsigned B_LPI       = 5;
  localparam int unsigned B_CRS       = 6;
  localparam int unsigned B_RNDADR    = 7;
  localparam int unsigned B_FILL      = 8;
  localparam int unsigned B_TXCHK     = 10;
  localparam int unsigned B_RXCHK     = 11;
  localparam int unsigned B_LDCLR     = 12;
  localparam int unsigned B_QUAL1     = 13;
  localparam int unsigned B_QUAL2     = 14;
  localparam int unsigned B_PCLR      = 15;

  localparam logic [1:0]  FILL_ZERO   = 2'h1;
  localparam logic [1:0]  FILL_ONES   = 2'h2;

  localparam logic [15:0] CTRL_RST    = 16'h0000;
  localparam logic [15:0] FMASK_RST   = 16'h000f;
  localparam logic [15:0] SMASK_RST   = 16'h00ff;
  localparam logic [15:0] SMIN_RST    = 16'h0010;

  typedef struct packed {
    logic [11:0] paddr;
    logic        pwrite;
    logic [31:0] pwdata;
    logic        psel;
    logic        penable;
  } ets_apb_req_t;

  typedef struct packed {
    logic [7:0] d;
    logic       en;
    logic       er;
  } ets_gmii_t;

  typedef enum logic [5:0] {
    S_IDLE  = 6'h01,
    S_FRM   = 6'h02,
    S_IFG   = 6'h04,
    S_GAP   = 6'h08,
    S_SLEEP = 6'h10,
    S_WAKE  = 6'h20
  } ets_gen_t;

  function automatic logic [31:0] ets_crc_byte(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] r;
    r = c ^ {24'h000000, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

endpackage

// *** ets_crc_chk.sv ***
// Frame checksum checker that watches one byte stream and reports each frame.
`timescale 1ns/100ps
`default_nettype none
module ets_crc_chk
  import ets_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  input  wire ets_gmii_t  data_i,
  output logic            good_o,
  output logic            bad_o,
  output logic [47:0]     dest_o
);

  typedef struct packed {
    logic        act;
    logic        sfd;
    logic [2:0]  nda;
    logic [31:0] crc;
    logic        err;
    logic [47:0] da;
    logic        good;
    logic        bad;
  } ets_chk_t;

  ets_chk_t s_q, s_d;

  always_comb begin
    s_d      = s_q;
    s_d.good = 1'b0;
    s_d.bad  = 1'b0;
    s_d.act  = data_i.en;
    if (data_i.en) begin
      if (!s_q.act) begin
        s_d.sfd = 1'b0;
        s_d.nda = 3'h0;
        s_d.crc = CRC_INIT;
        s_d.err = 1'b0;
      end
      if (data_i.er) begin
        s_d.err = 1'b1;
      end
      if (s_q.act && s_q.sfd) begin
        s_d.crc = ets_crc_byte(s_q.crc, data_i.d);
        if (s_q.nda != 3'h6) begin
          s_d.da  = {s_q.da[39:0], data_i.d};
          s_d.nda = s_q.nda + 3'h1;
        end
      end else if (data_i.d == SFD_BYTE) begin
        s_d.sfd = 1'b1;
      end
    end else if (s_q.act && s_q.sfd) begin
      s_d.good = (s_q.crc == CRC_RESIDUE) && !s_q.err;
      s_d.bad  = !((s_q.crc == CRC_RESIDUE) && !s_q.err);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign good_o = s_q.good;
  assign bad_o  = s_q.bad;
  assign dest_o = s_q.da;

endmodule // ets_crc_chk
`default_nettype wire

// *** ets_link_model.sv ***
// Loopback line partner with link status and carrier low-power timer.
`timescale 1ns/100ps
`default_nettype none
module ets_link_model
  import ets_pkg::*;
#(
  parameter int unsigned WAKE_DLY = 150
) (
  input  wire logic      clk_sys_i,
  input  wire logic      rst_i,
  input  wire ets_gmii_t tx_i,
  input  wire logic      lpi_i,
  input  wire logic      link_req_i,
  output ets_gmii_t      rx_o,
  output logic           link_up_o,
  output logic           crs_done_o
);
  int unsigned quiet_q;
  // Released receive data toggles so that no stale byte is seen.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rx_o      <= '0;
      link_up_o <= 1'b0;
      quiet_q   <= 0;
    end else begin
      rx_o      <= tx_i.en ? tx_i : ets_gmii_t'{d: ~rx_o.d, en: 1'b0, er: 1'b0};
      link_up_o <= link_req_i;
      quiet_q   <= lpi_i ? 0 : quiet_q + 1;
    end
  end
  assign crs_done_o = (quiet_q >= WAKE_DLY);
endmodule // ets_link_model
`default_nettype wire

// *** ets_top_test.sv ***
// Self-checking testbench of the Ethernet self-test block.
`timescale 1ns/100ps
`default_nettype none
module ets_top_test
  import ets_pkg::*;
;
  localparam int unsigned RUN_LEN  = 3000;
  localparam int unsigned WAKE_DLY = 150;
  localparam logic [47:0] DA1      = 48'h0a0b0c0d0e01;
  localparam logic [47:0] DA2      = 48'h0a0b0c0d0e02;
  logic         clk_sys_i, rst_i, lreq, pready, pslverr, lpi, lup, crs, er;
  logic         p_en, p_lpi, fell, lpi_seen, crs_mode, rnd;
  ets_apb_req_t apb;
  ets_gmii_t    mac, rx, tx;
  logic [31:0]  prdata, rd, c, s1, s2;
  logic [47:0]  p;
  logic [1:0]   fill;
  logic [7:0]   fq[$];
  int           n_mismatch, checks_done, frames, gap_n, lpi_n, since, burst_n;
  int           b2b, crs_hits, f0, smin, fmask;

  ets_top #(.RUN_LEN(RUN_LEN)) uut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .apb_i(apb),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .mac_tx_i(mac),
    .line_rx_i(rx), .line_tx_o(tx), .line_lpi_o(lpi), .link_up_i(lup),
    .crs_timer_done_i(crs));
  ets_link_model #(.WAKE_DLY(WAKE_DLY)) far (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .tx_i(tx), .lpi_i(lpi), .link_req_i(lreq), .rx_o(rx), .link_up_o(lup),
    .crs_done_o(crs));

  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  task automatic complete_run;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask

  function automatic logic [31:0] fcs(input logic [31:0] x, input logic [7:0] b);
    for (int j = 0; j < 8; j++) x = (x[0] ^ b[j]) ? (x >> 1) ^ CRC_POLY : x >> 1;
    return x;
  endfunction

  task xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge clk_sys_i);
    apb <= '{paddr: a, pwrite: w, pwdata: d, psel: 1'b1, penable: 1'b0};
    @(posedge clk_sys_i);
    apb.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_mismatch++;
      complete_run;
    end
    rd = prdata;
    er = pslverr;
    apb.psel <= 1'b0;
    apb.penable <= 1'b0;
  endtask

  task rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0);
    chk(nm, e, rd);
  endtask

  task send(input logic bad);
    logic [7:0]  f[$];
    logic [31:0] x;
    x = CRC_INIT;
    for (int i = 0; i < 8; i++) f.push_back((i == 7) ? SFD_BYTE : PRE_BYTE);
    for (int i = 0; i < 60; i++) begin
      f.push_back(8'(i));
      x = fcs(x, 8'(i));
    end
    x = ~x ^ {31'h0, bad};
    for (int i = 0; i < 4; i++) f.push_back(x[8*i +: 8]);
    foreach (f[i]) begin
      @(posedge clk_sys_i);
      mac <= '{d: f[i], en: 1'b1, er: 1'b0};
    end
    @(posedge clk_sys_i);
    mac <= '0;
    repeat (4) @(posedge clk_sys_i);
  endtask

  task start(input logic [31:0] v);
    burst_n = 0;
    xfer(OFS_CTRL, 1'b1, v & ~32'h7); // Force and setup first.
    xfer(OFS_CTRL, 1'b1, v & ~32'h6); // Master enable.
    xfer(OFS_CTRL, 1'b1, v & ~32'h4); // Burst mode.
    xfer(OFS_CTRL, 1'b1, v); // Run enable last.
  endtask

  task stop(input logic [31:0] v);
    int n;
    xfer(OFS_CTRL, 1'b1, v & ~32'h4);
    n = 0;
    do begin
      xfer(OFS_STATUS, 1'b0, 32'h0);
      n++;
    end while (rd[5:0] !== 6'h01 && n < 800);
    chk("stop", 32'h1, {26'h0, rd[5:0]}); // Generator halts.
    if (rd[5:0] !== 6'h01) complete_run;
  endtask

  task waitf(input int k);
    int n;
    n = 0;
    while (frames < k && n < 30000) begin
      @(posedge clk_sys_i);
      n++;
    end
    chk("frames", 1, {31'h0, frames >= k}); // Bursts keep coming.
    if (frames < k) complete_run;
  endtask

  task frame_chk;
    logic [47:0] da;
    int          n;
    n = fq.size();
    da = '0;
    frames++;
    for (int i = 0; i < 8; i++) chk("pre", (i == 7) ? 32'hd5 : 32'h55, {24'h0, fq[i]});
    for (int i = 8; i < 14; i++) da = {da[39:0], fq[i]};
    if (fill == 2'h0) begin
      chk("len", n - 26, {16'h0, fq[20], fq[21]}); // Length field.
      if (rnd) chk("rnd", 0, {31'h0, da === DA1 || da === DA2 || da[40]}); // Random address.
      else chk("pair", 1, {31'h0, da === DA1 || da === DA2}); // Stored pair used.
    end else begin
      for (int i = 8; i < n - 4; i++)
        chk("fill", (fill == FILL_ONES) ? 32'hff : 32'h0, {24'h0, fq[i]}); // Forced fill.
    end
    fq.delete();
  endtask

  always @(posedge clk_sys_i) begin
    if (tx.en === 1'b1) begin
      if (p_en !== 1'b1) begin
        if (frames > 0) chk("ifg", 1, {31'h0, gap_n >= 12}); // Minimum gap.
        if (gap_n >= 12 && gap_n <= 14) b2b++;
        if (crs_mode && fell) begin
          chk("wake", 1, {31'h0, since >= WAKE_DLY}); // Carrier timer wake.
          crs_hits++;
        end
        fell = 1'b0;
        burst_n++;
      end
      if (tx.er !== 1'b0) chk("tx_er", 32'h0, {31'h0, tx.er}); // No error flag.
      fq.push_back(tx.d);
      gap_n = 0;
    end else begin
      if (p_en === 1'b1) frame_chk();
      gap_n++;
    end
    if (lpi === 1'b1) begin
      if (p_lpi !== 1'b1) begin
        chk("burst", 1, {31'h0, burst_n >= 1 && burst_n <= (fmask | 1)}); // Burst size.
        burst_n = 0;
      end
      lpi_seen = 1'b1;
      lpi_n++;
    end else if (p_lpi === 1'b1) begin
      chk("sleep", 1, {31'h0, lpi_n >= smin}); // Sleep minimum.
      lpi_n = 0;
      fell = 1'b1;
      since = 0;
    end
    since++;
    p_en = tx.en;
    p_lpi = lpi;
  end

  initial begin
    rst_i = 1'b1;
    lreq = 1'b0;
    apb = '0;
    mac = '0;
    fill = 2'h0;
    {p_en, p_lpi, fell, lpi_seen, crs_mode, rnd} = '0;
    {n_mismatch, checks_done, frames, gap_n, lpi_n, since, burst_n, b2b, crs_hits} = '0;
    smin = 0;
    fmask = 0;
    repeat (6) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    rchk("ctrl", OFS_CTRL, {16'h0, CTRL_RST});
    rchk("fmask", OFS_FMASK, {16'h0, FMASK_RST});
    rchk("smask", OFS_SMASK, {16'h0, SMASK_RST});
    rchk("smin", OFS_SMIN, {16'h0, SMIN_RST});
    rchk("unmapped", 12'h100, 32'h0);
    chk("slverr", 32'h1, {31'h0, er});
    xfer(OFS_CTRL, 1'b1, 32'h400);
    send(1'b0);
    send(1'b1);
    rchk("tx_good", OFS_CNT + 12'h8, 32'h1); // Good frame counted.
    rchk("tx_bad", OFS_CNT + 12'hc, 32'h1); // Errored frame counted.
    chk("tx_pass", 0, frames); // Line output untouched.
    xfer(OFS_CTRL, 1'b1, 32'h0);
    rchk("tx_clr", OFS_CNT + 12'h8, 32'h0); // Disable clears.
    send(1'b0);
    rchk("tx_off", OFS_CNT + 12'h8, 32'h0); // No count when off.
    for (int i = 0; i < 4; i++) begin
      p = i[1] ? DA2 : DA1;
      xfer(OFS_PAIR + 12'(8 * i), 1'b1, p[31:0]);
      xfer(OFS_PAIR + 12'(8 * i + 4), 1'b1, {16'h0, p[47:32]});
    end
    fmask = 3;
    smin = 32;
    xfer(OFS_FMASK, 1'b1, 32'h3);
    xfer(OFS_SMASK, 1'b1, 32'h1f);
    xfer(OFS_SMIN, 1'b1, 32'h20);
    start(32'h6827);
    repeat (300) @(posedge clk_sys_i);
    chk("no_link", 0, frames); // Wait for link.
    lreq <= 1'b1;
    waitf(6);
    stop(32'h6827);
    f0 = frames;
    repeat (300) @(posedge clk_sys_i);
    chk("halt", f0, frames); // Stays stopped.
    xfer(OFS_CNT, 1'b0, 32'h0);
    s1 = rd;
    xfer(OFS_CNT + 12'h4, 1'b0, 32'h0);
    s2 = rd;
    chk("sent", frames, s1 + s2); // Sent per pair.
    rchk("rx1_good", OFS_CNT + 12'h10, s1); // Qualified by pair one.
    rchk("rx2_good", OFS_CNT + 12'h18, s2); // Qualified by pair two.
    rchk("rx1_bad", OFS_CNT + 12'h14, 32'h0); // Checksum is right.
    chk("lpi_on", 1, {31'h0, lpi_seen}); // Sleep signalled.
    xfer(OFS_CTRL, 1'b1, 32'h8800);
    xfer(OFS_CTRL, 1'b1, 32'h1800);
    rchk("pclr", OFS_CNT, 32'h0); // Set then clear.
    lreq <= 1'b0;
    repeat (5) @(posedge clk_sys_i);
    rchk("ldclr1", OFS_CNT + 12'h10, 32'h0); // Link drop clears.
    rchk("ldclr2", OFS_CNT + 12'h18, 32'h0); // Link drop clears.
    lreq <= 1'b0; // Force bit stands in for the missing link.
    for (int f = 0; f < 3; f++) begin
      fill = 2'(f);
      lpi_seen = 1'b0;
      crs_mode = (f == 1);
      c = 32'h80f | (32'(f) << 8) | ((f > 0) ? 32'h20 : 32'h0) | (crs_mode ? 32'h40 : 32'h0);
      start(c);
      waitf(frames + 4);
      stop(c);
      if (f == 0) chk("lpi_off", 0, {31'h0, lpi_seen}); // No sleep signal.
    end
    chk("crs_seen", 1, {31'h0, crs_hits > 0}); // Wake timed.
    chk("b2b", 1, {31'h0, b2b > 0}); // Back to back.
    fill = 2'h0;
    rnd = 1'b1;
    lreq <= 1'b1;
    f0 = frames;
    start(32'h89f);
    repeat (RUN_LEN + 2000) @(posedge clk_sys_i);
    chk("timed_run", 1, {31'h0, frames > f0}); // Frames before the stop.
    f0 = frames;
    repeat (1500) @(posedge clk_sys_i);
    chk("timed", f0, frames); // Timed stop.
    xfer(OFS_CNT + 12'h10, 1'b0, 32'h0);
    chk("rx_live", 1, {31'h0, rd != 32'h0}); // Counts when on.
    xfer(OFS_CTRL, 1'b1, 32'h0);
    rchk("rx_clr", OFS_CNT + 12'h10, 32'h0); // Disable clears.
    complete_run;
  end
endmodule // ets_top_test
`default_nettype wire
